/* File: pmt_pkg.sv */
// Constants, register map and types for the transceiver management block.
// Assumes a 40 MHz system clock and a clause 22 management bus.
package pmt_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_ACCESS   = 8'h60;
  localparam logic [7:0] OFF_TBI_CTRL = 8'h64;
  localparam logic [7:0] OFF_ADV      = 8'h68;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h70;
  localparam logic [7:0] OFF_IRQ_CLR  = 8'h74;
  localparam logic [7:0] OFF_IRQ_EN   = 8'h78;
  localparam logic [7:0] OFF_MODE     = 8'h7C;

  // Control/status bit positions
  localparam int B_XRST     = 31;
  localparam int B_LOOP     = 30;
  localparam int B_AN_EN    = 29;
  localparam int B_AN_RST   = 28;
  localparam int B_LINK_UP  = 25;
  localparam int B_AN_DONE  = 24;
  localparam int B_RF_HI    = 13;
  localparam int B_RF_LO    = 12;
  localparam int B_PS_HI    = 8;
  localparam int B_PS_LO    = 7;
  localparam int B_FD       = 5;

  // Interrupt events
  localparam int IRQ_W      = 4;
  localparam int EV_ACCESS  = 0;
  localparam int EV_LINK    = 1;
  localparam int EV_AN_DONE = 2;
  localparam int EV_XRST    = 3;

  // Management frame fields
  localparam logic [4:0]  XCVR_ADDR   = 5'h01;
  localparam logic [31:0] PREAMBLE    = 32'hFFFFFFFF;
  localparam logic [1:0]  FR_START    = 2'h1;
  localparam logic [1:0]  OP_WRITE    = 2'h1;
  localparam logic [1:0]  OP_READ     = 2'h2;
  localparam logic [1:0]  TA_WRITE    = 2'h2;
  localparam int          FRAME_BITS  = 64;
  localparam int          TA_BIT      = 46;
  localparam int          DATA_BIT    = 48;

  // Timing
  localparam int SYS_CLK_NS    = 25;
  localparam int MDC_PERIOD_NS = 320;
  localparam int MDC_HALF_CYC  = (MDC_PERIOD_NS + 2 * SYS_CLK_NS - 1) / (2 * SYS_CLK_NS);
  localparam int XRST_NS       = 10000;
  localparam int XRST_CYC      = (XRST_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

  // Access register layout
  typedef struct packed {
    logic        dir;
    logic [9:0]  rsvd;
    logic [4:0]  xcvr_reg_select;
    logic [15:0] xcvr_reg_value;
  } pmt_access_t;

  typedef enum logic [0:0] {
    ST_IDLE  = 1'b0,
    ST_FRAME = 1'b1
  } pmt_state_t;

endpackage : pmt_pkg

/* File: pmt_phy_mgmt.sv */
// Transceiver management access and ten-bit interface control/status.
// Assumes pins from the transceiver and ten-bit logic are asynchronous to
// sys_clk; MDC is made here from sys_clk by a divider.
`timescale 1ns/10ps

// Function
// R1 - Frames always carry transceiver address 00001
// R2 - Flag 1 writes, clears when done
// R3 - Flag 0 reads, sets when done
// R4 - Bits 20:16 select transceiver register
// R5 - Bits 15:0 carry register data
// R6 - Bit 31 resets transceiver, self-clears
// R7 - Bit 30 signals transceiver loopback
// R8 - Bit 29 enables auto-negotiation
// R9 - Bit 28 restarts negotiation, clears on completion
// R10 - Bit 25 shows link established
// R11 - Bit 24 shows negotiation complete
// R12 - Bits 13:12 hold remote fault code
// R13 - Bits 8:7 hold pause abilities
// R14 - Advertisement bit 5 always reads 1
// R15 - Strapped mode bit selects ten-bit mode
// R16 - MDC period 320ns, 64 clocks each; the divider rounds up to 350ns (7 sys_clk per half)
// R17 - One clause 22 frame per request
// R18 - Reserved bits read zero, writes ignored
module pmt_phy_mgmt #(
  parameter int RST_CYC = pmt_pkg::XRST_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [31:0] rdata,
  output logic             irq,
  output logic             mdc,
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe,
  output logic             xcvr_reset_n,
  input  wire logic        tbi_link_in,
  input  wire logic        tbi_an_done_in,
  input  wire logic        mode_strap,
  output logic             xcvr_loopback,
  output logic             autoneg_enable,
  output logic             autoneg_restart,
  output logic      [15:0] adv_word,
  output logic             tenbit_mode_sel
);
  import pmt_pkg::*;

  localparam int NSYNC = 4;

  pmt_access_t        acc;
  pmt_state_t         state;
  logic [NSYNC-1:0]   sync1;
  logic [NSYNC-1:0]   sync2;
  logic [NSYNC-1:0]   async_in;
  logic               mdio_s;
  logic               link_s;
  logic               an_s;
  logic               link_q;
  logic               an_q;
  logic               strap_taken;
  logic [3:0]         half_cnt;
  logic               half_tick;
  logic [6:0]         bit_cnt;
  logic [FRAME_BITS-1:0] shreg;
  logic [15:0]        rd_shift;
  logic               frame_end;
  logic               xrst_busy;
  logic [15:0]        xrst_cnt;
  logic               xrst_done;
  logic               an_restart_bit;
  logic [1:0]         rf_code;
  logic [1:0]         pause_adv;
  logic [IRQ_W-1:0]   irq_stat;
  logic [IRQ_W-1:0]   irq_en;
  logic [IRQ_W-1:0]   irq_evt;
  logic [IRQ_W-1:0]   irq_clr;
  logic               wr_acc;
  logic               wr_ctrl;
  logic               wr_adv;
  logic               an_rise;
  logic [31:0]        next_rdata;

  assign async_in = {mode_strap, tbi_an_done_in, tbi_link_in, mdio_in};

  // Two-stage synchronisers; only the second stage is used by logic.
  // They run through reset on purpose: the strap is taken on the first
  // edge after release, so the chain must already hold the pin level then.
  // Cost: the chain shows unknowns until the clock has run two edges,
  // which any reset longer than two cycles covers.
  for (genvar i = 0; i < NSYNC; i++) begin : g_sync
    always_ff @(posedge sys_clk) begin
      sync1[i] <= async_in[i];
      sync2[i] <= sync1[i];
    end
  end

  assign mdio_s = sync2[0];
  assign link_s = sync2[1];
  assign an_s   = sync2[2];

  assign wr_acc  = wr_en && (addr == OFF_ACCESS);
  assign wr_ctrl = wr_en && (addr == OFF_TBI_CTRL);
  assign wr_adv  = wr_en && (addr == OFF_ADV);
  assign an_rise = an_s && !an_q;

  // Edge history of the synchronised status inputs.
  // Kept tracking through reset so that a status input already high at
  // release does not look like a fresh edge and raise a false event.
  always_ff @(posedge sys_clk) begin
    link_q <= link_s;
    an_q   <= an_s;
  end

  // Mode strap caught once after reset release, then held
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      strap_taken     <= 1'b0;
      tenbit_mode_sel <= 1'b0;
    end else if (!strap_taken) begin
      strap_taken     <= 1'b1;
      tenbit_mode_sel <= sync2[3]; // [R15]
    end
  end

  // MDC half-period divider, runs only during a frame
  // Half period is rounded up, so MDC is never faster than its limit.
  always_ff @(posedge sys_clk) begin
    if (rst || state == ST_IDLE) begin
      half_cnt <= 4'h0;
    end else if (half_tick) begin
      half_cnt <= 4'h0;
    end else begin
      half_cnt <= half_cnt + 4'h1;
    end
  end
  assign half_tick = (half_cnt == 4'(MDC_HALF_CYC - 1)); // [R16]
  assign frame_end = half_tick && mdc && (bit_cnt == 7'(FRAME_BITS - 1));

  // Frame sequencer: data changes on MDC falling, sampled on rising
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state    <= ST_IDLE;
      mdc      <= 1'b0;
      mdio_out <= 1'b0;
      mdio_oe  <= 1'b0;
      bit_cnt  <= 7'h00;
      shreg    <= '0;
      rd_shift <= 16'h0000;
    end else begin
      unique case (state)
        ST_IDLE: begin
          // The whole frame is built at once; the transceiver address is fixed,
          // software only chooses the register, the direction and the data.
          if (wr_acc) begin // [R17]
            state   <= ST_FRAME;
            bit_cnt <= 7'h00;
            mdc     <= 1'b0;
            mdio_oe <= 1'b1;
            mdio_out <= 1'b1;
            shreg   <= {PREAMBLE, FR_START,
                        wdata[31] ? OP_WRITE : OP_READ, // [R2] [R3]
                        XCVR_ADDR, // [R1]
                        wdata[20:16], // [R4]
                        TA_WRITE, wdata[15:0]}; // [R5]
          end
        end
        ST_FRAME: begin
          if (half_tick) begin
            mdc <= !mdc;
            if (!mdc) begin
              // Rising edge: capture read data bits
              if (bit_cnt >= 7'(DATA_BIT)) begin
                rd_shift <= {rd_shift[14:0], mdio_s};
              end
            end else if (frame_end) begin
              state    <= ST_IDLE;
              mdio_oe  <= 1'b0;
              mdio_out <= 1'b0;
            end else begin
              // Falling edge: present next bit
              bit_cnt  <= bit_cnt + 7'h01;
              shreg    <= {shreg[FRAME_BITS-2:0], 1'b0};
              mdio_out <= shreg[FRAME_BITS-2];
              // Release the line for turnaround on reads
              if (!acc.dir && bit_cnt == 7'(TA_BIT - 1)) begin
                mdio_oe <= 1'b0;
              end
            end
          end
        end
      endcase
    end
  end

  // Access register; writes while a frame runs are ignored
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      acc <= '0;
    end else if (state == ST_IDLE && wr_acc) begin
      acc.dir             <= wdata[31];
      acc.xcvr_reg_select <= wdata[20:16];
      acc.xcvr_reg_value  <= wdata[15:0];
      acc.rsvd            <= '0; // [R18]
    end else if (frame_end) begin
      acc.dir <= !acc.dir; // [R2] [R3]
      if (!acc.dir) begin
        // All sixteen data bits were taken on the rising edges before this
        // falling edge; shifting once more here would drop the top bit.
        acc.xcvr_reg_value <= rd_shift; // [R3] [R5]
      end
    end
  end

  // Transceiver reset request and hold counter.
  // A second request while the pulse runs is ignored rather than stretching
  // it, so software always sees one pulse of fixed length per request.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      xrst_busy    <= 1'b0;
      xrst_cnt     <= 16'h0000;
      xcvr_reset_n <= 1'b1;
    end else if (!xrst_busy && wr_ctrl && wdata[B_XRST]) begin
      xrst_busy    <= 1'b1;
      xrst_cnt     <= 16'(RST_CYC - 1);
      xcvr_reset_n <= 1'b0; // [R6]
    end else if (xrst_busy) begin
      if (xrst_cnt == 16'h0000) begin
        xrst_busy    <= 1'b0; // [R6]
        xcvr_reset_n <= 1'b1;
      end else begin
        xrst_cnt <= xrst_cnt - 16'h0001;
      end
    end
  end
  assign xrst_done = xrst_busy && (xrst_cnt == 16'h0000);

  // Loopback and negotiation enable
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      xcvr_loopback  <= 1'b0;
      autoneg_enable <= 1'b0;
    end else if (wr_ctrl) begin
      xcvr_loopback  <= wdata[B_LOOP]; // [R7]
      autoneg_enable <= wdata[B_AN_EN]; // [R8]
    end
  end

  // Restart bit: a new write wins over completion in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      an_restart_bit  <= 1'b0;
      autoneg_restart <= 1'b0;
    end else begin
      autoneg_restart <= wr_ctrl && wdata[B_AN_RST]; // [R9]
      if (wr_ctrl && wdata[B_AN_RST]) begin
        an_restart_bit <= 1'b1;
      end else if (an_rise) begin
        an_restart_bit <= 1'b0; // [R9]
      end
    end
  end

  // Advertisement fields
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rf_code   <= 2'h0;
      pause_adv <= 2'h0;
    end else if (wr_adv) begin
      rf_code   <= wdata[B_RF_HI:B_RF_LO]; // [R12]
      pause_adv <= wdata[B_PS_HI:B_PS_LO]; // [R13]
    end
  end

  // Word advertised to the ten-bit logic, full duplex forced on
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      adv_word <= 16'h0000;
    end else begin
      adv_word              <= 16'h0000;
      adv_word[B_RF_HI:B_RF_LO] <= rf_code;
      adv_word[B_PS_HI:B_PS_LO] <= pause_adv;
      adv_word[B_FD]        <= 1'b1; // [R14]
    end
  end

  // Interrupt events, sticky status; set wins over clear.
  // An event in the cycle of a clear write survives, so software that clears
  // and then reads status never misses it.
  assign irq_evt[EV_ACCESS]  = frame_end;
  assign irq_evt[EV_LINK]    = link_s != link_q;
  assign irq_evt[EV_AN_DONE] = an_rise;
  assign irq_evt[EV_XRST]    = xrst_done;
  assign irq_clr = (wr_en && addr == OFF_IRQ_CLR) ? wdata[IRQ_W-1:0] : '0;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_stat <= '0;
      irq_en   <= '0;
      irq      <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_evt;
      if (wr_en && addr == OFF_IRQ_EN) begin
        irq_en <= wdata[IRQ_W-1:0];
      end
      irq <= |(irq_stat & irq_en);
    end
  end

  // Read mux; reserved and unmapped bits read zero
  always_comb begin
    next_rdata = 32'h00000000;
    unique case (addr)
      OFF_ACCESS:   next_rdata = acc; // [R18]
      OFF_TBI_CTRL: begin
        next_rdata[B_XRST]    = xrst_busy;
        next_rdata[B_LOOP]    = xcvr_loopback;
        next_rdata[B_AN_EN]   = autoneg_enable;
        next_rdata[B_AN_RST]  = an_restart_bit;
        next_rdata[B_LINK_UP] = link_s; // [R10]
        next_rdata[B_AN_DONE] = an_s; // [R11]
      end
      OFF_ADV:      next_rdata = {16'h0000, adv_word};
      OFF_IRQ_STAT: next_rdata[IRQ_W-1:0] = irq_stat;
      OFF_IRQ_EN:   next_rdata[IRQ_W-1:0] = irq_en;
      OFF_MODE:     next_rdata[0] = tenbit_mode_sel;
      default:      next_rdata = 32'h00000000;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  // Zero outside that cycle keeps a stale word off the bus.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata <= 32'h00000000;
    end else begin
      rdata <= rd_en ? next_rdata : 32'h00000000;
    end
  end

endmodule : pmt_phy_mgmt

/* File: pmt_phy_mgmt_checker.sv */
// Checker: timing relations on the management block ports.
// Assumes the bind hands down the reset pulse length.
`timescale 1ns/10ps
module pmt_phy_mgmt_checker #(
  parameter int RST_CYC = 4
) (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr_en,
  input wire logic [15:0] adv_word,
  input wire logic        mdc,
  input wire logic        mdio_oe,
  input wire logic        xcvr_reset_n,
  input wire logic        xcvr_loopback,
  input wire logic        autoneg_enable,
  input wire logic        autoneg_restart
);
  import pmt_pkg::*;
  logic ctl_wr;
  logic rs_wr;
  logic xr_wr;
  int   low_cnt;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Control writes that may move the control outputs
  assign ctl_wr = wr_en && addr == OFF_TBI_CTRL;
  assign rs_wr  = ctl_wr && wdata[B_AN_RST];
  assign xr_wr  = ctl_wr && wdata[B_XRST];
  // Counts the low cycles of the transceiver reset
  always_ff @(posedge sys_clk) low_cnt <= (rst || xcvr_reset_n) ? 0 : low_cnt + 1;
  adv_fixed_a: assert property (!$past(rst) |-> (adv_word & 16'hCE7F) == 16'h0020)
    else $error("advert fixed bits wrong");
  mdc_half_a: assert property ($rose(mdc) |-> mdc [*7] ##1 !mdc)
    else $error("mdc high phase wrong");
  loop_src_a: assert property ($changed(xcvr_loopback) |-> $past(ctl_wr) || $past(ctl_wr, 2))
    else $error("loopback moved without write");
  an_src_a: assert property ($changed(autoneg_enable) |-> $past(ctl_wr) || $past(ctl_wr, 2))
    else $error("negotiation enable moved without write");
  restart_pulse_a: assert property (autoneg_restart |-> $past(rs_wr) || $past(rs_wr, 2))
    else $error("restart pulse without write");
  xrst_src_a: assert property ($fell(xcvr_reset_n) |-> $past(xr_wr) || $past(xr_wr, 2))
    else $error("transceiver reset without write");
  xrst_len_a: assert property ($rose(xcvr_reset_n) |-> low_cnt == RST_CYC)
    else $error("transceiver reset length wrong");
  oe_start_a: assert property ($rose(mdio_oe) |-> $past(wr_en) && $past(addr) == OFF_ACCESS)
    else $error("frame without access write");
endmodule : pmt_phy_mgmt_checker

bind pmt_phy_mgmt pmt_phy_mgmt_checker #(.RST_CYC(RST_CYC)) chk (.*);

/* File: pmt_xcvr_model.sv */
// Transceiver model: management slave at address 00001.
// Assumes mdio has a pull-up and mdc stands low between frames.
`timescale 1ns/10ps
module pmt_xcvr_model (
  input  wire logic        mdc,
  input  wire logic        mdio_out,
  input  wire logic        mdio_oe,
  output logic             mdio_in,
  output logic      [63:0] frame
);
  logic [15:0] mem [32];
  logic [63:0] sh;
  logic [15:0] rd;
  logic        rdop;
  logic        drv;
  logic        dbit;
  int          cnt;
  initial begin
    for (int i = 0; i < 32; i++) mem[i] = 16'h0;
    frame = '0;
    rdop = 1'b0;
    drv = 1'b0;
    dbit = 1'b0;
    cnt = 0;
  end
  // Pull-up wins when nobody drives, so stale data never lingers
  assign mdio_in = mdio_oe ? mdio_out : (drv ? dbit : 1'b1);
  // Shift in the wire level on each rising edge
  always @(posedge mdc) begin
    if (cnt != 0 || mdio_oe) begin
      sh = {sh[62:0], mdio_in};
      cnt = cnt + 1;
      if (cnt == 46) begin
        rdop = sh[11:10] == 2'h2 && sh[9:5] == 5'h01;
        rd = mem[sh[4:0]];
      end
      if (cnt == 64) begin
        if (sh[29:28] == 2'h1 && sh[27:23] == 5'h01) mem[sh[22:18]] = sh[15:0];
        frame = sh;
        cnt = 0;
        rdop = 1'b0;
      end
    end
  end
  // Turnaround zero, then data MSB first, after each falling edge
  always @(negedge mdc) begin
    drv = rdop && cnt >= 47;
    dbit = (cnt >= 48) ? rd[63 - cnt] : 1'b0;
  end
endmodule : pmt_xcvr_model

/* File: pmt_phy_mgmt_tb.sv */
// Testbench: register traffic, management frames and ten-bit status.
// Assumes the transceiver model answers at address 00001.
`timescale 1ns/10ps
module pmt_phy_mgmt_tb;
  import pmt_pkg::*;
  logic        sys_clk, rst, wr_en, rd_en, irq, mdc, mdio_in, mdio_out, mdio_oe;
  logic        xcvr_reset_n, tbi_link_in, tbi_an_done_in, mode_strap;
  logic        xcvr_loopback, autoneg_enable, autoneg_restart, tenbit_mode_sel;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, seed, v, e;
  logic [15:0] adv_word, d;
  logic [4:0]  r;
  logic [63:0] frame;
  int          failures, num_checks;

  pmt_phy_mgmt #(.RST_CYC(4)) DUT (.*);
  pmt_xcvr_model XM (.*);

  always #12.5 sys_clk = ~sys_clk;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic logic [63:0] exp_frame(logic [1:0] op, logic [4:0] ra, logic [15:0] da);
    return {32'hFFFFFFFF, 2'h1, op, 5'h01, ra, 2'h2, da};
  endfunction : exp_frame

  task automatic chk(string n, logic [63:0] ex, logic [63:0] got);
    num_checks++;
    if (got !== ex) begin
      $display("CHECK FAILED %s expected %h seen %h", n, ex, got);
      failures++;
    end
  endtask : chk

  task automatic wr(logic [7:0] a, logic [31:0] dat);
    @(posedge sys_clk);
    addr <= a;
    wdata <= dat;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(logic [7:0] a);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    @(negedge sys_clk);
    v = rdata;
  endtask : rd

  // Poll the access flag; a frame lasts about 900 cycles
  task automatic poll(logic f);
    for (int i = 0; i < 600; i++) begin
      rd(OFF_ACCESS);
      if (v[31] === f) return;
    end
    failures++;
    summarize();
  endtask : poll

  task automatic summarize();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  initial begin
    {sys_clk, wr_en, rd_en, tbi_link_in, tbi_an_done_in} = '0;
    addr = 8'h00;
    wdata = 32'h0;
    mode_strap = 1'b1;
    rst = 1'b1;
    seed = 32'h8;
    failures = 0;
    num_checks = 0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    // Reset state, unmapped read and strap
    rd(OFF_TBI_CTRL); chk("ctrl", 0, v);
    rd(OFF_ADV); chk("adv", 32'h20, v);
    rd(8'h6C); chk("unmapped", 0, v);
    rd(OFF_MODE); chk("mode", {32'h1, 1'b1}, {v, tenbit_mode_sel});
    // Every fault and pause code with random reserved bits
    for (int i = 0; i < 16; i++) begin
      v = xs();
      v[13:12] = i[3:2];
      v[8:7] = i[1:0];
      e = (v & 32'h3180) | 32'h20;
      wr(OFF_ADV, v);
      rd(OFF_ADV); chk("adv rw", e, v);
      chk("adv pin", e[15:0], adv_word);
    end
    // Write then read back; first write is hit by a busy write
    for (int i = 0; i < 4; i++) begin
      v = xs();
      r = v[20:16];
      d = v[15:0];
      v[31] = 1'b1;
      wr(OFF_ACCESS, v);
      if (i == 0) wr(OFF_ACCESS, ~v);
      poll(1'b0);
      chk("wr frame", exp_frame(2'h1, r, d), frame);
      wr(OFF_ACCESS, {1'b0, 10'h3FF, r, ~d});
      poll(1'b1);
      chk("rd frame", exp_frame(2'h2, r, d), frame);
      chk("rd data", {1'b1, 10'h0, r, d}, v);
    end
    // Completion event: masked, enabled, cleared
    chk("irq masked", 0, irq);
    rd(OFF_IRQ_STAT); chk("irq stat", 1, v[0]);
    wr(OFF_IRQ_EN, 32'h1);
    repeat (2) @(negedge sys_clk);
    chk("irq on", 1, irq);
    wr(OFF_IRQ_CLR, 32'hF);
    repeat (2) @(negedge sys_clk);
    chk("irq off", 0, irq);
    // Loopback and enable with reserved and read-only bits set
    wr(OFF_TBI_CTRL, 32'h6FFFFFFF);
    rd(OFF_TBI_CTRL); chk("ctrl rw", 32'h60000000, v);
    chk("pins", 2'h3, {xcvr_loopback, autoneg_enable});
    // Link up, restart held until negotiation completes
    tbi_link_in <= 1'b1;
    wr(OFF_TBI_CTRL, 32'h30000000);
    rd(OFF_TBI_CTRL); chk("restart", 32'h32000000, v);
    chk("loop off", 0, xcvr_loopback);
    tbi_link_in <= 1'b0;
    tbi_an_done_in <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(OFF_TBI_CTRL); chk("an done", 32'h21000000, v);
    // Transceiver reset busy during the pulse, clear after it
    wr(OFF_TBI_CTRL, 32'hA0000000);
    rd(OFF_TBI_CTRL); chk("xrst busy", 32'hA1000000, v);
    chk("xrst pin", 0, xcvr_reset_n);
    repeat (10) @(posedge sys_clk);
    rd(OFF_TBI_CTRL); chk("xrst done", 32'h21000000, v);
    // Link rise and fall, negotiation done and reset done since the clear
    rd(OFF_IRQ_STAT);
    chk("irq events", 32'hE, v);
    summarize();
  end
endmodule : pmt_phy_mgmt_tb
